// File: rtl/ett_timer_counter.sv
// One eight-bit timer/counter channel: timer, divider and PWM modes; event counting is a clock source.
// Assumes source ticks arrive as one-cycle enables from an outside divider.
`timescale 1ns/100ps
`include "ett_map.svh"
module ett_timer_counter #(
  parameter int WIDTH = 8
) (
  // Clock and reset
  input  wire logic             ref_clk,
  input  wire logic             reset,
  // Control register
  input  wire logic [7:0]       timerControl,
  input  wire logic             controlWrite,
  input  wire logic [2:0]       operatingModeSelect,
  input  wire logic [2:0]       sourceClockSelect,
  // Internal source tick, one cycle per selected rate
  input  wire logic             internalTick,
  // Compare and duty registers
  input  wire logic [WIDTH-1:0] compareWriteData,
  input  wire logic             compareWrite,
  input  wire logic [WIDTH-1:0] dutyWriteData,
  input  wire logic             dutyWrite,
  output logic [WIDTH-1:0]      dutyReadData,
  // Pins and events
  input  wire logic             eventInputPin,
  output logic                  timerOutputPin,
  output logic                  timerMatchIrq,
  output logic [WIDTH-1:0]      counterValue
);
  logic             runBit;
  logic             flip;
  logic [WIDTH-1:0] compareRegister;
  logic [WIDTH-1:0] dutyBuffer;
  logic [WIDTH-1:0] dutyActive;
  logic             eventFall;
  logic             tick;
  logic             matchHit;
  logic             pwmOverflow;
  logic             periodIrq;
  ett_pkg::ett_op_t op;

  ett_edge_detect u_edge (
    .ref_clk   (ref_clk),
    .reset     (reset),
    .pinLevel  (eventInputPin),
    .fallPulse (eventFall)
  );

  // Mode decode
  always_comb begin
    case (operatingModeSelect)
      `ETT_MODE_TIMER:   op = ett_pkg::ETT_OP_COUNT;
      `ETT_MODE_DIVIDER: op = ett_pkg::ETT_OP_DIVIDER;
      `ETT_MODE_PWM:     op = ett_pkg::ETT_OP_PWM;
      default:           op = ett_pkg::ETT_OP_NONE;
    endcase
  end

  // Source 111 picks the event pin in every mode; other sources use the internal tick
  assign tick = runBit & ((sourceClockSelect == `ETT_SRC_EXTERNAL) ?
                eventFall : internalTick);

  assign matchHit    = tick & (op != ett_pkg::ETT_OP_PWM) & (op != ett_pkg::ETT_OP_NONE)
                       & (counterValue == compareRegister);
  assign pwmOverflow = tick & (op == ett_pkg::ETT_OP_PWM) & (&counterValue);
  assign periodIrq   = matchHit | pwmOverflow;

  // Run bit
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      runBit <= 1'b0;
    end else if (controlWrite) begin
      runBit <= timerControl[`ETT_CTRL_RUN_BIT];
    end
  end

  // Counter
  always_ff @(posedge ref_clk) begin
    if (reset || !runBit) begin
      counterValue <= `ETT_CNT_RESET;
    end else if (matchHit) begin
      counterValue <= `ETT_CNT_RESET;
    end else if (tick) begin
      counterValue <= counterValue + 1'b1;
    end
  end

  // Output flip-flop; software load only while stopped keeps the held level
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      flip <= 1'b0;
    end else if (controlWrite && !runBit) begin
      flip <= timerControl[`ETT_CTRL_FLIP_BIT];
    end else if (op == ett_pkg::ETT_OP_DIVIDER && matchHit) begin
      flip <= ~flip;
    end else if (op == ett_pkg::ETT_OP_PWM && tick &&
                 ((counterValue == dutyActive) || (&counterValue))) begin
      flip <= ~flip;
    end
  end

  // Stopped timer gets no ticks, so the pin holds its level except on a control write
  assign timerOutputPin = ~flip;

  // Compare register, unbuffered
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      compareRegister <= `ETT_CMP_RESET;
    end else if (compareWrite) begin
      compareRegister <= compareWriteData;
    end
  end

  // Duty buffer and active register
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      dutyBuffer <= `ETT_DUTY_RESET;
    end else if (dutyWrite) begin
      dutyBuffer <= dutyWriteData;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      dutyActive <= `ETT_DUTY_RESET;
    end else if (dutyWrite && !runBit) begin
      dutyActive <= dutyWriteData;
    end else if (pwmOverflow) begin
      dutyActive <= dutyBuffer;
    end
  end

  assign dutyReadData = dutyActive;

  // Interrupt pulse registered one cycle after the event
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      timerMatchIrq <= 1'b0;
    end else begin
      timerMatchIrq <= periodIrq;
    end
  end

  sequence s_pwm_wrap;
    pwmOverflow;
  endsequence

  a_match_clear: assert property (@(posedge ref_clk) disable iff (reset)
    matchHit |=> counterValue == '0 && timerMatchIrq)
    else $error("match did not clear counter and raise irq");
  a_tick_count: assert property (@(posedge ref_clk) disable iff (reset)
    tick && !matchHit && runBit && !controlWrite |=>
    counterValue == $past(counterValue) + 1'b1)
    else $error("counter did not advance on tick");
  a_idle_hold: assert property (@(posedge ref_clk) disable iff (reset)
    !tick && runBit && !controlWrite |=> counterValue == $past(counterValue))
    else $error("counter moved without tick");
  a_div_toggle: assert property (@(posedge ref_clk) disable iff (reset)
    op == ett_pkg::ETT_OP_DIVIDER && matchHit && !controlWrite |=>
    timerOutputPin != $past(timerOutputPin))
    else $error("divider output did not toggle");
  a_pin_inverse: assert property (@(posedge ref_clk) disable iff (reset)
    timerOutputPin == ~flip)
    else $error("pin not inverse of flip-flop");
  a_stop_hold: assert property (@(posedge ref_clk) disable iff (reset)
    !runBit && !controlWrite |=> $stable(timerOutputPin))
    else $error("stopped output changed");
  a_stop_clear: assert property (@(posedge ref_clk) disable iff (reset)
    !runBit |=> counterValue == '0)
    else $error("counter not cleared while stopped");
  a_duty_xfer: assert property (@(posedge ref_clk) disable iff (reset)
    s_pwm_wrap and !(dutyWrite && !runBit) |=> dutyReadData == $past(dutyBuffer))
    else $error("duty not transferred at period");
  a_duty_hold: assert property (@(posedge ref_clk) disable iff (reset)
    runBit && !pwmOverflow |=> $stable(dutyReadData))
    else $error("active duty changed mid period");
  a_pwm_irq: assert property (@(posedge ref_clk) disable iff (reset)
    s_pwm_wrap |=> timerMatchIrq ##1 !timerMatchIrq || periodIrq)
    else $error("pwm overflow irq wrong");
endmodule // ett_timer_counter

// File: common/ett_map.svh
// Constants for the eight-bit timer/counter channel.
// Assumes inclusion by bare name from rtl files.
`ifndef ETT_MAP_SVH
`define ETT_MAP_SVH
`define ETT_CTRL_RUN_BIT   3
`define ETT_CTRL_FLIP_BIT  7
`define ETT_MODE_TIMER     3'h0
`define ETT_MODE_DIVIDER   3'h1
`define ETT_MODE_PWM       3'h2
`define ETT_SRC_EXTERNAL   3'h7
`define ETT_CNT_RESET      8'h00
`define ETT_CMP_RESET      8'h00
`define ETT_DUTY_RESET     8'h00
`endif

// File: common/ett_pkg.sv
// Types for the eight-bit timer/counter channel.
// Assumes nothing of its surroundings.
package ett_pkg;
  typedef enum logic [1:0] {
    ETT_OP_COUNT,
    ETT_OP_DIVIDER,
    ETT_OP_PWM,
    ETT_OP_NONE
  } ett_op_t;
endpackage

// File: rtl/ett_edge_detect.sv
// Falling-edge detector for the event input pin.
// Assumes the pin is synchronous to ref_clk.
`timescale 1ns/100ps
module ett_edge_detect (
  // Clock and reset
  input  wire logic ref_clk,
  input  wire logic reset,
  // Pin and pulse
  input  wire logic pinLevel,
  output logic      fallPulse
);
  logic lastLevel;

  // Starts high so a pin low at reset release reads as a falling edge
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      lastLevel <= 1'b1;
    end else begin
      lastLevel <= pinLevel;
    end
  end

  assign fallPulse = lastLevel & ~pinLevel;
endmodule // ett_edge_detect

// File: dv/ett_event_model.sv
// Partner model: external event source on the event input pin.
// Assumes the bench clock; drives the pin at the falling edge.
`timescale 1ns/100ps
module ett_event_model (
  // Clock
  input  wire logic ref_clk,
  // Event pin, idles high
  output logic      eventPin
);
  initial eventPin = 1'b1;
  // Both levels last at least two cycles, though the edge detector catches one-cycle levels
  task automatic pulses(input int n, input int hold);
    int h;
    h = (hold < 2) ? 2 : hold;
    repeat (n) begin
      @(negedge ref_clk) eventPin = 1'b0;
      repeat (h) @(negedge ref_clk);
      eventPin = 1'b1;
      repeat (h - 1) @(negedge ref_clk);
    end
  endtask
endmodule // ett_event_model

// File: dv/tb_top.sv
// Self-checking bench for one timer/counter channel.
// Assumes the event model compiles first.
`timescale 1ns/100ps
module tb_top;
  logic       ref_clk = 1'b0;
  logic       reset = 1'b1;
  logic [7:0] timerControl = 8'h00;
  logic       controlWrite = 1'b0;
  logic [2:0] mode = 3'h0;
  logic [2:0] src = 3'h0;
  logic       internalTick = 1'b0;
  logic [7:0] wrData = 8'h00;
  logic       compareWrite = 1'b0;
  logic       dutyWrite = 1'b0;
  logic [7:0] dutyReadData, counterValue;
  logic       eventPin, timerOutputPin, timerMatchIrq;
  logic [7:0] irqCount = 8'h00;
  int         miscompares = 0;
  int         checks_done = 0;
  int         cycles = 0;

  initial forever #4 ref_clk = ~ref_clk;

  ett_event_model ev (.ref_clk(ref_clk), .eventPin(eventPin));

  ett_timer_counter i_dut (
    .ref_clk(ref_clk), .reset(reset), .timerControl(timerControl),
    .controlWrite(controlWrite), .operatingModeSelect(mode),
    .sourceClockSelect(src), .internalTick(internalTick),
    .compareWriteData(wrData), .compareWrite(compareWrite),
    .dutyWriteData(wrData), .dutyWrite(dutyWrite), .dutyReadData(dutyReadData),
    .eventInputPin(eventPin), .timerOutputPin(timerOutputPin),
    .timerMatchIrq(timerMatchIrq), .counterValue(counterValue));

  always @(posedge ref_clk) begin
    if (timerMatchIrq === 1'b1) irqCount <= irqCount + 8'h01;
    cycles++;
    if (cycles == 5000) begin
      miscompares++;
      tally_and_finish();
    end
  end

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string m);
    checks_done++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask

  // sel 0 control, 1 compare, 2 duty; one-cycle strobe
  task automatic wr(input int sel, input logic [7:0] v);
    @(negedge ref_clk);
    timerControl = v;
    wrData = v;
    {dutyWrite, compareWrite, controlWrite} = 3'h1 << sel;
    @(negedge ref_clk) {dutyWrite, compareWrite, controlWrite} = 3'h0;
  endtask

  // Extra cycle at the end lets the irq pulse reach irqCount
  task automatic tickN(input int n);
    @(negedge ref_clk) internalTick = 1'b1;
    repeat (n) @(negedge ref_clk);
    internalTick = 1'b0;
    @(negedge ref_clk);
  endtask

  initial begin
    repeat (6) @(negedge ref_clk);
    reset = 1'b0;
    chk(counterValue, 8'h00, "cnt rst");
    chk({7'h0, timerOutputPin}, 8'h01, "pin rst");
    chk(dutyReadData, 8'h00, "duty rst");
    wr(1, 8'h03);
    wr(0, 8'h08);
    tickN(3);
    chk(counterValue, 8'h03, "tmr cnt");
    chk(irqCount, 8'h00, "tmr early irq");
    tickN(1);
    chk(counterValue, 8'h00, "tmr clr");
    chk(irqCount, 8'h01, "tmr irq");
    tickN(2);
    chk(counterValue, 8'h02, "tmr resume");
    wr(0, 8'h00);
    // Run bit drops at the strobe edge; the clear lands one edge later
    @(negedge ref_clk);
    chk(counterValue, 8'h00, "stop clr");
    src = 3'h7;
    wr(1, 8'h02);
    wr(0, 8'h08);
    ev.pulses(2, 2);
    tickN(3);
    chk(counterValue, 8'h02, "evt cnt");
    ev.pulses(1, 3);
    chk(counterValue, 8'h00, "evt clr");
    chk(irqCount, 8'h02, "evt irq");
    wr(0, 8'h00);
    mode = 3'h1;
    src = 3'h0;
    wr(1, 8'h01);
    wr(0, 8'h08);
    tickN(2);
    chk({7'h0, timerOutputPin}, 8'h00, "div pin");
    chk(irqCount, 8'h03, "div irq");
    tickN(2);
    chk({7'h0, timerOutputPin}, 8'h01, "div toggle");
    tickN(2);
    wr(0, 8'h80);
    tickN(2);
    chk({7'h0, timerOutputPin}, 8'h00, "div hold");
    wr(0, 8'h00);
    chk({7'h0, timerOutputPin}, 8'h01, "flip load");
    mode = 3'h2;
    wr(2, 8'h10);
    chk(dutyReadData, 8'h10, "duty stopped");
    wr(0, 8'h08);
    tickN(17);
    chk({7'h0, timerOutputPin}, 8'h00, "pwm duty");
    chk(counterValue, 8'h11, "pwm cnt");
    wr(2, 8'h20);
    chk(dutyReadData, 8'h10, "duty active");
    tickN(238);
    chk(irqCount, 8'h05, "pwm no irq");
    tickN(1);
    chk(counterValue, 8'h00, "pwm wrap");
    chk({7'h0, timerOutputPin}, 8'h01, "pwm ovf");
    chk(irqCount, 8'h06, "pwm irq");
    chk(dutyReadData, 8'h20, "duty xfer");
    tickN(33);
    chk({7'h0, timerOutputPin}, 8'h00, "pwm new duty");
    wr(0, 8'h00);
    chk({7'h0, timerOutputPin}, 8'h00, "pwm hold");
    tally_and_finish();
  end
endmodule // tb_top
